// ---- include/srl_cfg.svh ----
// offsets, field positions, the PMC1 reset value, implemented-bit mask and part identifier of the routing register bank
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH
`define SRL_OFS_IPS1    12'h000
`define SRL_OFS_IPS2    12'h004
`define SRL_OFS_IPS3    12'h008
`define SRL_OFS_CO      12'h00c
`define SRL_OFS_CCS     12'h010
`define SRL_OFS_PRSC_H  12'h014
`define SRL_OFS_PRSC_L  12'h018
`define SRL_OFS_ID_H    12'h01c
`define SRL_OFS_ID_L    12'h020
`define SRL_OFS_PMC1    12'h024
`define SRL_OFS_PMC2    12'h028
`define SRL_OFS_INPUTS  12'h02c
`define SRL_PMC1_RESET  8'h1c
`define SRL_IPS2_IMPL   8'h3d
`define SRL_IPS1_T3CS   5
`define SRL_IPS1_PCSS   3
`define SRL_IPS1_T2CS   2
`define SRL_RXSRC_BIT   5
`define SRL_MODEN_BIT   0
`define SRL_DDRV_BIT    1
`define SRL_PMC1_FLAG   7
`define SRL_PMC1_ACK    6
`define SRL_PMC1_IE     5
`define SRL_PMC1_RE     4
`define SRL_PMC1_SE     3
`define SRL_PMC1_DE     2
`define SRL_PMC1_BGDS   1
`define SRL_PMC1_BANDGAP_BUFFER_ENABLE   0
`define SRL_PART_ID     12'h5a7 // arbitrary identifier value
`endif

// ---- include/srl_pkg.sv ----
// types shared by the routing register bank
package srl_pkg;
    typedef enum logic [1:0] {
        SRL_BUS_IDLE  = 2'b00,
        SRL_BUS_WRITE = 2'b01,
        SRL_BUS_READ  = 2'b10
    } srl_phase_t;
    typedef enum logic [3:0] {
        SRL_CO_OFF  = 4'h0,
        SRL_CO_OSC1 = 4'h1,
        SRL_CO_OSC2 = 4'h2,
        SRL_CO_IRC  = 4'h3,
        SRL_CO_BUS  = 4'h4,
        SRL_CO_CORE = 4'h5,
        SRL_CO_LPO  = 4'h6,
        SRL_CO_CNV0 = 4'h8,
        SRL_CO_CNV1 = 4'h9
    } srl_clksel_t;
endpackage

// ---- src/srl_bank.sv ----
// system routing and low-voltage control register bank on an ahb-lite slave
// Function
// - timer clock selects: pin or first-timer overflow
// - pulse counter input: pin or comparator
// - serial1 receive: pin or comparator 0
// - 3-bit timebase field picks modulation source
// - serial1 modulate enable gates timebase on
// - select-two unimplemented bits read 1 once written
// - serial2 receive: pin or comparator 1
// - serial2 own timebase field and enable
// - select-three bit1 doubles serial2 drive
// - filter clock: osc1, bus, rtc 512Hz; the bus setting drives a constant 1 here
// - 4-bit field muxes clock output pin
// - clock generator external: osc2 default, osc1
// - nonzero 11-bit match divides output clock
// - match split high bits 2-0, low 7-0
// - read-only 12-bit identifier, writes ignored
// - flag set on detect, ack bit clears
// - irq enable requests interrupt while flag set
// - reset enable forces chip reset on flag while detect enable is set
// - stop enable keeps detection during stop
// - detect and reset enables write-once
// - bandgap buffer enable and drive select
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "srl_cfg.svh"
module srl_bank (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 timerClkPin,
    input  wire logic                 timerOverflow,
    input  wire logic                 pcntPinDigital,
    input  wire logic                 pcntPinCompared,
    input  wire logic                 rx1Pin,
    input  wire logic                 rx2Pin,
    input  wire logic                 cmp0Out,
    input  wire logic                 cmp1Out,
    input  wire logic [6:0]           timebaseSrc,
    input  wire logic                 tx1Data,
    input  wire logic                 tx2Data,
    input  wire logic                 osc1Clk,
    input  wire logic                 rtc512Clk,
    input  wire logic [9:0]           clkOutSrc,
    input  wire logic                 lowVoltageEvent,
    input  wire logic                 stopMode,
    output logic                      timer3ClkOut,
    output logic                      timer2ClkOut,
    output logic                      pcntInputOut,
    output logic                      rx1Out,
    output logic                      rx2Out,
    output logic                      tx1PinOut,
    output logic                      tx2PinOut,
    output logic                      tx2DoubleDrive,
    output logic                      pcntFilterClkOut,
    output logic                      clockOutputPin,
    output logic                      clkgenExtSel,
    output logic                      lowVoltageIrq,
    output logic                      lowVoltageReset,
    output logic                      bandgapBufferEnable,
    output logic                      bandgapDriveSelect,
    output logic                      detectActive
);
    import srl_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        srl_phase_t  phase;
        logic [11:0] addr;
        logic [7:0]  ips1;
        logic [7:0]  ips2;
        logic [7:0]  ips3;
        logic [7:0]  co;
        logic [7:0]  ccs;
        logic [2:0]  prscH;
        logic [7:0]  prscL;
        logic [7:0]  pmc1;
        logic [7:0]  pmc2;
        logic        onceDone;
        logic [10:0] divCnt;
        logic        divOut;
        logic        ckOut;
        logic [31:0] rdata;
        logic        t3, t2, pulse_counter, rx1, rx2, tx1, tx2, ddrv, fclk, cko, ext;
        logic        irq, rstReq, bgE, bgD, detAct;
    } srl_state_t;

    srl_state_t st_reg;
    srl_state_t st_next;

    function automatic logic pickTimebase(input logic [2:0] sel, input logic [6:0] src);
        pickTimebase = (sel == 3'b111) ? 1'b0 : src[sel];
    endfunction

    // literal bits cannot be selected directly, so name the identifier
    localparam logic [11:0] partId = `SRL_PART_ID;

    logic [10:0] matchVal;
    logic        selClk;
    logic        detectOn;
    logic [7:0]  wByte;

    always_comb begin
        st_next  = st_reg;
        matchVal = {st_reg.prscH, st_reg.prscL};
        wByte    = hwdata[7:0];
        detectOn = st_reg.pmc1[`SRL_PMC1_DE] &&
                   (!stopMode || st_reg.pmc1[`SRL_PMC1_SE]);
        // ------------------------------------------------------------
        // bus data phase; registers are bytes in the low lane
        // ------------------------------------------------------------
        if (st_reg.phase == SRL_BUS_WRITE) begin
            if (st_reg.addr == `SRL_OFS_IPS1) begin
                st_next.ips1 = wByte;
            end else if (st_reg.addr == `SRL_OFS_IPS2) begin
                // unimplemented positions latch to one once written
                st_next.ips2 = (wByte & `SRL_IPS2_IMPL) | ~`SRL_IPS2_IMPL;
            end else if (st_reg.addr == `SRL_OFS_IPS3) begin
                st_next.ips3 = wByte;
            end else if (st_reg.addr == `SRL_OFS_CO) begin
                st_next.co = {4'h0, wByte[3:0]};
            end else if (st_reg.addr == `SRL_OFS_CCS) begin
                st_next.ccs = {7'h00, wByte[0]};
            end else if (st_reg.addr == `SRL_OFS_PRSC_H) begin
                st_next.prscH = wByte[2:0];
            end else if (st_reg.addr == `SRL_OFS_PRSC_L) begin
                st_next.prscL = wByte;
            end else if (st_reg.addr == `SRL_OFS_PMC1) begin
                st_next.pmc1[`SRL_PMC1_IE]   = wByte[`SRL_PMC1_IE];
                st_next.pmc1[`SRL_PMC1_SE]   = wByte[`SRL_PMC1_SE];
                st_next.pmc1[`SRL_PMC1_BGDS] = wByte[`SRL_PMC1_BGDS];
                st_next.pmc1[`SRL_PMC1_BANDGAP_BUFFER_ENABLE] = wByte[`SRL_PMC1_BANDGAP_BUFFER_ENABLE];
                if (!st_reg.onceDone) begin
                    st_next.pmc1[`SRL_PMC1_RE] = wByte[`SRL_PMC1_RE];
                    st_next.pmc1[`SRL_PMC1_DE] = wByte[`SRL_PMC1_DE];
                    st_next.onceDone           = 1'b1;
                end
                if (wByte[`SRL_PMC1_ACK]) begin
                    st_next.pmc1[`SRL_PMC1_FLAG] = 1'b0;
                end
            end else if (st_reg.addr == `SRL_OFS_PMC2) begin
                st_next.pmc2 = wByte;
            end
        end
        // detection set wins over a same-cycle acknowledge
        if (lowVoltageEvent && detectOn) begin
            st_next.pmc1[`SRL_PMC1_FLAG] = 1'b1;
        end
        // ------------------------------------------------------------
        // address phase
        // ------------------------------------------------------------
        st_next.phase = SRL_BUS_IDLE;
        if (hsel && hready && htrans[1]) begin
            st_next.addr  = haddr;
            st_next.phase = hwrite ? SRL_BUS_WRITE : SRL_BUS_READ;
        end
        st_next.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == `SRL_OFS_IPS1) begin
                st_next.rdata[7:0] = st_reg.ips1;
            end else if (haddr == `SRL_OFS_IPS2) begin
                st_next.rdata[7:0] = st_reg.ips2;
            end else if (haddr == `SRL_OFS_IPS3) begin
                st_next.rdata[7:0] = st_reg.ips3;
            end else if (haddr == `SRL_OFS_CO) begin
                st_next.rdata[7:0] = st_reg.co;
            end else if (haddr == `SRL_OFS_CCS) begin
                st_next.rdata[7:0] = st_reg.ccs;
            end else if (haddr == `SRL_OFS_PRSC_H) begin
                st_next.rdata[7:0] = {5'h00, st_reg.prscH};
            end else if (haddr == `SRL_OFS_PRSC_L) begin
                st_next.rdata[7:0] = st_reg.prscL;
            end else if (haddr == `SRL_OFS_ID_H) begin
                // upper nibble is undefined; reads as zero here
                st_next.rdata[7:0] = {4'h0, partId[11:8]};
            end else if (haddr == `SRL_OFS_ID_L) begin
                st_next.rdata[7:0] = partId[7:0];
            end else if (haddr == `SRL_OFS_PMC1) begin
                st_next.rdata[7:0] = st_reg.pmc1 & ~(8'h01 << `SRL_PMC1_ACK);
            end else if (haddr == `SRL_OFS_PMC2) begin
                st_next.rdata[7:0] = st_reg.pmc2;
            end else if (haddr == `SRL_OFS_INPUTS) begin
                st_next.rdata[7:0] = {stopMode, lowVoltageEvent, st_reg.divOut,
                                      5'h00};
            end
        end
        // ------------------------------------------------------------
        // clock output prescaler: toggles each match+1 cycles
        // ------------------------------------------------------------
        case (st_reg.co[3:0])
            SRL_CO_OSC1: selClk = clkOutSrc[1];
            SRL_CO_OSC2: selClk = clkOutSrc[2];
            SRL_CO_IRC:  selClk = clkOutSrc[3];
            SRL_CO_BUS:  selClk = clkOutSrc[4];
            SRL_CO_CORE: selClk = clkOutSrc[5];
            SRL_CO_LPO:  selClk = clkOutSrc[6];
            SRL_CO_CNV0: selClk = clkOutSrc[8];
            SRL_CO_CNV1: selClk = clkOutSrc[9];
            default:     selClk = 1'b0;
        endcase
        // selected clock is sampled, so the divider counts its rising edges
        if (matchVal == 11'h000 || st_reg.co[3:0] == SRL_CO_OFF) begin
            st_next.divCnt = 11'h000;
            st_next.divOut = 1'b0;
            st_next.cko    = selClk;
        end else begin
            if (selClk && !st_reg.cko) begin
                if (st_reg.divCnt >= matchVal) begin
                    st_next.divCnt = 11'h000;
                    st_next.divOut = !st_reg.divOut;
                end else begin
                    st_next.divCnt = st_reg.divCnt + 11'h001;
                end
            end
            st_next.cko = selClk;
        end
        // pin gets its own flop so the output never comes from a mux
        st_next.ckOut = (matchVal == 11'h000) ? st_next.cko : st_next.divOut;
        // ------------------------------------------------------------
        // routing outputs
        // ------------------------------------------------------------
        st_next.t3   = st_reg.ips1[`SRL_IPS1_T3CS] ? timerOverflow : timerClkPin;
        st_next.t2   = st_reg.ips1[`SRL_IPS1_T2CS] ? timerOverflow : timerClkPin;
        st_next.pulse_counter = st_reg.ips1[`SRL_IPS1_PCSS] ? pcntPinCompared : pcntPinDigital;
        st_next.rx1  = st_reg.ips2[`SRL_RXSRC_BIT] ? cmp0Out : rx1Pin;
        st_next.rx2  = st_reg.ips3[`SRL_RXSRC_BIT] ? cmp1Out : rx2Pin;
        st_next.tx1  = st_reg.ips2[`SRL_MODEN_BIT] ?
                       (tx1Data & pickTimebase(st_reg.ips2[4:2], timebaseSrc))
                       : tx1Data;
        st_next.tx2  = st_reg.ips3[`SRL_MODEN_BIT] ?
                       (tx2Data & pickTimebase(st_reg.ips3[4:2], timebaseSrc))
                       : tx2Data;
        st_next.ddrv = st_reg.ips3[`SRL_DDRV_BIT];
        case (st_reg.ips3[7:6])
            2'b00:   st_next.fclk = osc1Clk;
            // bus clock sampled on its own rising edge is always high
            2'b01:   st_next.fclk = 1'b1;
            2'b10:   st_next.fclk = rtc512Clk;
            default: st_next.fclk = 1'b0;
        endcase
        st_next.ext    = st_reg.ccs[0];
        st_next.irq    = st_reg.pmc1[`SRL_PMC1_IE] && st_reg.pmc1[`SRL_PMC1_FLAG];
        st_next.rstReq = st_reg.pmc1[`SRL_PMC1_RE] && st_reg.pmc1[`SRL_PMC1_DE]
                         && st_reg.pmc1[`SRL_PMC1_FLAG];
        st_next.bgE    = st_reg.pmc1[`SRL_PMC1_BANDGAP_BUFFER_ENABLE];
        st_next.bgD    = st_reg.pmc1[`SRL_PMC1_BGDS];
        st_next.detAct = detectOn;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg      <= '0;
            st_reg.pmc1 <= `SRL_PMC1_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // the filter clock and the undivided clock output are sampled copies;
    // sources near bus rate alias, a limit of the single-clock design
    assign hrdata              = st_reg.rdata;
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign timer3ClkOut        = st_reg.t3;
    assign timer2ClkOut        = st_reg.t2;
    assign pcntInputOut        = st_reg.pulse_counter;
    assign rx1Out              = st_reg.rx1;
    assign rx2Out              = st_reg.rx2;
    assign tx1PinOut           = st_reg.tx1;
    assign tx2PinOut           = st_reg.tx2;
    assign tx2DoubleDrive      = st_reg.ddrv;
    assign pcntFilterClkOut    = st_reg.fclk;
    assign clockOutputPin      = st_reg.ckOut;
    assign clkgenExtSel        = st_reg.ext;
    assign lowVoltageIrq       = st_reg.irq;
    assign lowVoltageReset     = st_reg.rstReq;
    assign bandgapBufferEnable = st_reg.bgE;
    assign bandgapDriveSelect  = st_reg.bgD;
    assign detectActive        = st_reg.detAct;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_irq;
        @(posedge clk) disable iff (rst)
        st_reg.pmc1[`SRL_PMC1_IE] && st_reg.pmc1[`SRL_PMC1_FLAG] |=> lowVoltageIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_rst;
        @(posedge clk) disable iff (rst)
        (st_reg.pmc1[4] && st_reg.pmc1[2] && st_reg.pmc1[7]) |=> lowVoltageReset;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not forced");

    property p_flagset;
        @(posedge clk) disable iff (rst)
        lowVoltageEvent && detectOn |=> st_reg.pmc1[`SRL_PMC1_FLAG];
    endproperty
    a_flagset: assert property (p_flagset) else $error("flag lost");

    property p_once;
        @(posedge clk) disable iff (rst)
        st_reg.onceDone |=> $stable(st_reg.pmc1[`SRL_PMC1_DE]);
    endproperty
    a_once: assert property (p_once) else $error("write-once changed");

    property p_rx1;
        @(posedge clk) disable iff (rst)
        st_reg.ips2[5] |=> rx1Out == $past(cmp0Out);
    endproperty
    a_rx1: assert property (p_rx1) else $error("rx1 route wrong");

    property p_rx2;
        @(posedge clk) disable iff (rst)
        !st_reg.ips3[5] |=> rx2Out == $past(rx2Pin);
    endproperty
    a_rx2: assert property (p_rx2) else $error("rx2 route wrong");

    property p_nomod;
        @(posedge clk) disable iff (rst)
        !st_reg.ips2[0] |=> tx1PinOut == $past(tx1Data);
    endproperty
    a_nomod: assert property (p_nomod) else $error("tx1 modulated");

    property p_mod;
        @(posedge clk) disable iff (rst)
        st_reg.ips3[0] && !tx2Data |=> !tx2PinOut;
    endproperty
    a_mod: assert property (p_mod) else $error("tx2 not gated");

    property p_ips2;
        @(posedge clk) disable iff (rst)
        st_reg.phase == SRL_BUS_WRITE && st_reg.addr == `SRL_OFS_IPS2
        |=> st_reg.ips2[7:6] == 2'b11 && st_reg.ips2[1];
    endproperty
    a_ips2: assert property (p_ips2) else $error("unimpl bits not one");

    property p_t3;
        @(posedge clk) disable iff (rst)
        st_reg.ips1[5] |=> timer3ClkOut == $past(timerOverflow);
    endproperty
    a_t3: assert property (p_t3) else $error("timer3 route wrong");

    property p_ddrv;
        @(posedge clk) disable iff (rst)
        st_reg.ips3[`SRL_DDRV_BIT] |=> tx2DoubleDrive;
    endproperty
    a_ddrv: assert property (p_ddrv) else $error("double drive not set");

    property p_ext;
        @(posedge clk) disable iff (rst)
        !st_reg.ccs[0] |=> !clkgenExtSel;
    endproperty
    a_ext: assert property (p_ext) else $error("ext clock select wrong");

    property p_clkbyp;
        @(posedge clk) disable iff (rst)
        st_reg.co[3:0] == SRL_CO_OSC1 && {st_reg.prscH, st_reg.prscL} == 11'h000
        |=> clockOutputPin == $past(clkOutSrc[1]);
    endproperty
    a_clkbyp: assert property (p_clkbyp) else $error("bypass clock wrong");
endmodule

// ---- sim/tb_system_routing_and_lvd_control.sv ----
// self-checking bench of the routing and low-voltage register bank
`timescale 1ns/1ps
`include "srl_cfg.svh"
module tb_system_routing_and_lvd_control;
    import srl_pkg::*;
    logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q;
    logic        timerClkPin, timerOverflow, pcntPinDigital, pcntPinCompared;
    logic        rx1Pin, rx2Pin, cmp0Out, cmp1Out, tx1Data, tx2Data, osc1Clk, rtc512Clk;
    logic        lowVoltageEvent, stopMode;
    logic [6:0]  timebaseSrc;
    logic [9:0]  clkOutSrc;
    logic        timer3ClkOut, timer2ClkOut, pcntInputOut, rx1Out, rx2Out, tx1PinOut;
    logic        tx2PinOut, tx2DoubleDrive, pcntFilterClkOut, clockOutputPin, clkgenExtSel;
    logic        lowVoltageIrq, lowVoltageReset, bandgapBufferEnable, bandgapDriveSelect;
    logic        detectActive;
    logic [7:0]  w, w3;
    int          fails, testsRun, n;

    // the single slave's ready is the bus ready
    assign hready = hreadyout;

    // ----
    // design
    // ----
    srl_bank dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timerClkPin(timerClkPin), .timerOverflow(timerOverflow),
        .pcntPinDigital(pcntPinDigital), .pcntPinCompared(pcntPinCompared),
        .rx1Pin(rx1Pin), .rx2Pin(rx2Pin), .cmp0Out(cmp0Out), .cmp1Out(cmp1Out),
        .timebaseSrc(timebaseSrc), .tx1Data(tx1Data), .tx2Data(tx2Data),
        .osc1Clk(osc1Clk), .rtc512Clk(rtc512Clk), .clkOutSrc(clkOutSrc),
        .lowVoltageEvent(lowVoltageEvent), .stopMode(stopMode),
        .timer3ClkOut(timer3ClkOut), .timer2ClkOut(timer2ClkOut),
        .pcntInputOut(pcntInputOut), .rx1Out(rx1Out), .rx2Out(rx2Out),
        .tx1PinOut(tx1PinOut), .tx2PinOut(tx2PinOut), .tx2DoubleDrive(tx2DoubleDrive),
        .pcntFilterClkOut(pcntFilterClkOut), .clockOutputPin(clockOutputPin),
        .clkgenExtSel(clkgenExtSel), .lowVoltageIrq(lowVoltageIrq),
        .lowVoltageReset(lowVoltageReset), .bandgapBufferEnable(bandgapBufferEnable),
        .bandgapDriveSelect(bandgapDriveSelect), .detectActive(detectActive)
    );

    // ----
    // expectations and helpers
    // ----
    function automatic logic tbPick(logic [2:0] c, logic [6:0] s);
        return (c == 3'h7) ? 1'b0 : s[c];
    endfunction

    function automatic logic coPick(logic [3:0] c, logic [9:0] s);
        if (c == 4'h0 || c == 4'h7 || c > 4'h9)
            return 1'b0;
        return s[c];
    endfunction

    function automatic logic fcPick(logic [1:0] c, logic o, logic r);
        return (c == 2'd0) ? o : (c == 2'd1) ? 1'b1 : (c == 2'd2) ? r : 1'b0;
    endfunction

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(int k);
        repeat (k) @(posedge clk);
    endtask

    // the slave never stalls today, but the waits stay in case it learns to
    task automatic bus(logic wr, logic [11:0] a, logic [7:0] d);
        @(posedge clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'b10, wr};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic randIn();
        @(posedge clk);
        {timerClkPin, timerOverflow, pcntPinDigital, pcntPinCompared} <= 4'($urandom);
        {rx1Pin, rx2Pin, cmp0Out, cmp1Out, tx1Data, tx2Data} <= 6'($urandom);
        {osc1Clk, rtc512Clk, timebaseSrc} <= 9'($urandom);
    endtask

    task automatic pulseLv();
        @(posedge clk);
        lowVoltageEvent <= 1'b1;
        @(posedge clk);
        lowVoltageEvent <= 1'b0;
        tick(3);
    endtask

    // start phase of the divider is unknown, so callers allow one or two edges of slack
    task automatic countToggles();
        logic prev;
        n = 0;
        prev = clockOutputPin;
        repeat (60) begin
            @(posedge clk);
            clkOutSrc[1] <= ~clkOutSrc[1];
            if (clockOutputPin !== prev)
                n++;
            prev = clockOutputPin;
        end
    endtask

    task automatic stopTest();
        if (fails == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----
    // clock and watchdog
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stopTest();
    end

    // ----
    // tests
    // ----
    initial begin
        {rst, hsize, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 3'b010, 48'h0};
        {timerClkPin, timerOverflow, pcntPinDigital, pcntPinCompared} = 4'h0;
        {rx1Pin, rx2Pin, cmp0Out, cmp1Out, tx1Data, tx2Data, osc1Clk, rtc512Clk} = 8'h0;
        {lowVoltageEvent, stopMode, timebaseSrc, clkOutSrc} = 19'h0;
        fails = 0;
        testsRun = 0;
        void'($urandom(7989));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("hreadyout", 32'h1, hreadyout);
        chk("extSelReset", 32'h0, clkgenExtSel);
        chk("detectReset", 32'h1, detectActive);
        for (int i = 0; i < 8; i++) begin
            w = (8'($urandom) & 8'hd3) | {2'b00, 1'(i >> 2), 1'b0, 1'(i >> 1), 1'(i), 2'b00};
            bus(1'b1, `SRL_OFS_IPS1, w);
            randIn();
            tick(3);
            chk("timer3", w[5] ? timerOverflow : timerClkPin, timer3ClkOut);
            chk("timer2", w[2] ? timerOverflow : timerClkPin, timer2ClkOut);
            chk("pcntIn", w[3] ? pcntPinCompared : pcntPinDigital, pcntInputOut);
        end
        for (int i = 0; i < 32; i++) begin
            w = (8'($urandom) & 8'he2) | {3'b000, 3'(i), 1'b0, 1'(i >> 3)};
            w3 = {2'(i >> 3), 1'($urandom), 3'(i), 1'($urandom), 1'(i >> 3)};
            bus(1'b1, `SRL_OFS_IPS2, w);
            bus(1'b1, `SRL_OFS_IPS3, w3);
            randIn();
            tick(3);
            chk("rx1", w[5] ? cmp0Out : rx1Pin, rx1Out);
            chk("tx1", w[0] ? tx1Data & tbPick(w[4:2], timebaseSrc) : tx1Data, tx1PinOut);
            chk("rx2", w3[5] ? cmp1Out : rx2Pin, rx2Out);
            chk("tx2", w3[0] ? tx2Data & tbPick(w3[4:2], timebaseSrc) : tx2Data, tx2PinOut);
            chk("serial2_tx_double_drive", w3[1], tx2DoubleDrive);
            chk("filterClk", fcPick(w3[7:6], osc1Clk, rtc512Clk), pcntFilterClkOut);
            bus(1'b0, `SRL_OFS_IPS2, 8'h0);
            chk("sel2", (w & 8'h3d) | 8'hc2, q);
            bus(1'b0, `SRL_OFS_IPS3, 8'h0);
            chk("sel3", w3, q);
        end
        bus(1'b1, `SRL_OFS_CCS, 8'h01);
        tick(3);
        chk("extSel", 32'h1, clkgenExtSel);
        bus(1'b1, `SRL_OFS_ID_H, 8'hff);
        bus(1'b1, `SRL_OFS_ID_L, 8'hff);
        bus(1'b0, `SRL_OFS_ID_H, 8'h0);
        chk("idHigh", 32'(`SRL_PART_ID >> 8), q & 32'h0f);
        bus(1'b0, `SRL_OFS_ID_L, 8'h0);
        chk("idLow", 32'(`SRL_PART_ID & 12'h0ff), q);
        bus(1'b1, 12'h040, 8'hff);
        bus(1'b0, 12'h040, 8'h0);
        chk("unmapped", 32'h0, q);
        w = 8'($urandom);
        bus(1'b1, `SRL_OFS_PMC2, w);
        bus(1'b0, `SRL_OFS_PMC2, 8'h0);
        chk("pmc2", w, q);
        bus(1'b1, `SRL_OFS_PRSC_H, 8'h05);
        bus(1'b0, `SRL_OFS_PRSC_H, 8'h0);
        chk("divHigh", 32'h5, q & 32'h07);
        bus(1'b1, `SRL_OFS_PRSC_H, 8'h00);
        bus(1'b1, `SRL_OFS_PRSC_L, 8'h00);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, `SRL_OFS_CO, 8'(c));
            @(posedge clk);
            clkOutSrc <= 10'($urandom);
            tick(4);
            chk("clock_output_pin", coPick(4'(c), clkOutSrc), clockOutputPin);
        end
        bus(1'b1, `SRL_OFS_CO, 8'h01);
        tick(4);
        countToggles();
        chk("bypassEdges", 32'h1, 32'(n >= 58 && n <= 60));
        bus(1'b1, `SRL_OFS_PRSC_L, 8'h02);
        bus(1'b0, `SRL_OFS_PRSC_L, 8'h0);
        chk("divLow", 32'h2, q);
        tick(4);
        countToggles();
        chk("dividedEdges", 32'h1, 32'(n >= 9 && n <= 11));
        bus(1'b0, `SRL_OFS_PMC1, 8'h0);
        chk("pmcReset", {24'h0, `SRL_PMC1_RESET}, q);
        pulseLv();
        chk("lvReset", 32'h1, lowVoltageReset);
        chk("irqOff", 32'h0, lowVoltageIrq);
        bus(1'b0, `SRL_OFS_PMC1, 8'h0);
        chk("flagSet", 32'h9c, q);
        bus(1'b1, `SRL_OFS_PMC1, 8'h67);
        tick(3);
        chk("lvResetOff", 32'h0, lowVoltageReset);
        chk("bgEnable", 32'h1, bandgapBufferEnable);
        chk("bgDrive", 32'h1, bandgapDriveSelect);
        bus(1'b0, `SRL_OFS_PMC1, 8'h0);
        chk("ackClear", 32'h27, q);
        @(posedge clk);
        stopMode <= 1'b1;
        tick(3);
        chk("stopOff", 32'h0, detectActive);
        pulseLv();
        bus(1'b0, `SRL_OFS_PMC1, 8'h0);
        chk("stopNoFlag", 32'h27, q);
        @(posedge clk);
        stopMode <= 1'b0;
        pulseLv();
        chk("irqOn", 32'h1, lowVoltageIrq);
        chk("lvResetLocked", 32'h0, lowVoltageReset);
        bus(1'b1, `SRL_OFS_PMC1, 8'h10);
        bus(1'b0, `SRL_OFS_PMC1, 8'h0);
        chk("writeOnce", 32'h84, q);
        bus(1'b1, `SRL_OFS_PMC1, 8'h40);
        bus(1'b0, `SRL_OFS_PMC1, 8'h0);
        chk("ackOnly", 32'h04, q);
        stopTest();
    end
endmodule
